// [rtl/sdbt_timer.v]
// Split-mode dual 8-bit down-counting timer with APB register bank
//
// How it works
// R1: CTRL bits 3:1 pick divide 1..1024
// R2: CTRL bit 0 enables counting
// R3: Channel enable drives waveform pin from compare
// R4: Idle level bits set pins while disabled
// R5: Split bit selects two 8-bit timers
// R6: Clear port write-one clears status bits
// R7: Set port write-one sets status bits
// R8: Both command ports read same status
// R9: Command field: update, restart, reset-if-disabled
// R10: Command field always reads zero
// R11: Enable bits 6:4 gate low compare interrupts
// R12: Enable bit 1 gates high underflow
// R13: Enable bit 0 gates low underflow
// R14: Low compare match sets sticky flag
// R15: High underflow sets sticky flag
// R16: Low underflow sets sticky flag
// R17: Debug halt stops timer unless run bit
// R18: Low counter write beats counting
// R19: Period registers hold TOP, reset all ones
// R20: Compares run continuously against counters
// R21: High counter write beats counting
// R22: Both count down per tick, reload at BOTTOM
// R23: Restart clears counters; update applies immediately
//
// The APB interface to the registers was chosen for this implementation.
`include "sdbt_consts.vh"

module sdbt_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire debug_halt,
  output reg [5:0] waveform_pin,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] ctrl_q;
  reg [7:0] cmpen_q;
  reg [7:0] oval_q;
  reg [7:0] split_q;
  reg [7:0] cmdstat_q;
  reg [7:0] inten_q;
  reg [7:0] flags_q;
  reg [7:0] dbg_q;
  reg [7:0] low_byte_counter_q;
  reg [7:0] high_byte_counter_q;
  reg [7:0] ltop_q;
  reg [7:0] htop_q;
  reg [7:0] cmp_q [0:5];
  reg [9:0] pre_q;
  reg [7:0] low_byte_counter_d;
  reg [7:0] high_byte_counter_d;
  reg [7:0] flags_d;
  wire [5:0] wave_d;

  // Word index match: each register owns one aligned word
  function sel_hit;
    input [31:0] a;
    input [7:0] idx;
    begin
      sel_hit = (a[31:2] == {22'h000000, idx});
    end
  endfunction

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  // A debug halt clears the prescaler and freezes both counters
  // unless the run-while-halted bit is set
  wire running = ctrl_q[`SDBT_ENABLE_BIT] & (dbg_q[0] | ~debug_halt); // R2 R17
  wire [2:0] div_sel = ctrl_q[`SDBT_DIVSEL_MSB:`SDBT_DIVSEL_LSB];
  wire [1:0] cmd_w = pwdata[`SDBT_CMD_MSB:`SDBT_CMD_LSB];
  wire cmd_wr = wr & (sel_hit(paddr, `SDBT_IDX_CMDCLR) | sel_hit(paddr, `SDBT_IDX_CMDSET));
  wire do_restart = cmd_wr & (cmd_w == `SDBT_CMD_RESTART);
  wire do_reset = cmd_wr & (cmd_w == `SDBT_CMD_RESET) & ~ctrl_q[`SDBT_ENABLE_BIT]; // R9
  wire do_update = cmd_wr & (cmd_w == `SDBT_CMD_UPDATE);
  wire low_byte_counter_wr = wr & sel_hit(paddr, `SDBT_IDX_LOW_BYTE_COUNTER);
  wire high_byte_counter_wr = wr & sel_hit(paddr, `SDBT_IDX_HIGH_BYTE_COUNTER);

  // Register decode shared by the write path
  wire hit_ctrl = sel_hit(paddr, `SDBT_IDX_CTRL);
  wire hit_cmpen = sel_hit(paddr, `SDBT_IDX_CMPEN);
  wire hit_oval = sel_hit(paddr, `SDBT_IDX_OVAL);
  wire hit_split = sel_hit(paddr, `SDBT_IDX_SPLIT);
  wire hit_cmdclr = sel_hit(paddr, `SDBT_IDX_CMDCLR);
  wire hit_cmdset = sel_hit(paddr, `SDBT_IDX_CMDSET);
  wire hit_inten = sel_hit(paddr, `SDBT_IDX_INTEN);
  wire hit_flags = sel_hit(paddr, `SDBT_IDX_FLAGS);
  wire hit_dbg = sel_hit(paddr, `SDBT_IDX_DBG);
  wire hit_ltop = sel_hit(paddr, `SDBT_IDX_LTOP);
  wire hit_htop = sel_hit(paddr, `SDBT_IDX_HTOP);
  wire hit_cmp = (paddr[31:2] >= {22'h000000, `SDBT_IDX_LCMP0}) &&
                 (paddr[31:2] <= {22'h000000, `SDBT_IDX_HCMP2});
  wire [2:0] cmp_idx = paddr[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler tick
  reg tick;
  always @* begin
    case (div_sel) // R1
      3'h0: tick = 1'b1;
      3'h1: tick = (pre_q[0] == 1'b1);
      3'h2: tick = (pre_q[1:0] == 2'h3);
      3'h3: tick = (pre_q[2:0] == 3'h7);
      3'h4: tick = (pre_q[3:0] == 4'hF);
      3'h5: tick = (pre_q[5:0] == 6'h3F);
      3'h6: tick = (pre_q[7:0] == 8'hFF);
      default: tick = (pre_q == 10'h3FF);
    endcase
  end

  // Prescale count restarts whenever the timer stops, so the first
  // tick after enable comes one full divide period later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 10'h000;
    end else if (!running || do_restart) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters, compares, flags, waveforms
  wire step = running & tick & split_q[0]; // R5 R22
  wire low_underflow = step & (low_byte_counter_q == `SDBT_ZERO8);
  wire high_underflow = step & (high_byte_counter_q == `SDBT_ZERO8);

  // Per-channel compare match and waveform level
  wire [2:0] low_hit;
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
      wire [7:0] low_cmp = cmp_q[2 * ch];
      wire [7:0] high_cmp = cmp_q[2 * ch + 1];
      assign low_hit[ch] = (low_byte_counter_q == low_cmp); // R20
      assign wave_d[ch] = ctrl_q[`SDBT_ENABLE_BIT] ?
        (cmpen_q[ch] & (low_byte_counter_q <= low_cmp)) : oval_q[ch]; // R3 R4
      assign wave_d[ch + 3] = ctrl_q[`SDBT_ENABLE_BIT] ?
        (cmpen_q[ch + 4] & (high_byte_counter_q <= high_cmp)) : oval_q[ch + 4]; // R3 R4 R20
    end
  endgenerate

  // Low-byte counter next value; a bus write has the last word
  always @* begin
    low_byte_counter_d = low_byte_counter_q;
    if (do_restart || do_reset) begin
      low_byte_counter_d = `SDBT_ZERO8; // R23
    end else if (step || do_update) begin
      low_byte_counter_d = (low_byte_counter_q == `SDBT_ZERO8) ? ltop_q : low_byte_counter_q - 8'h01; // R22
    end
    if (low_byte_counter_wr) begin
      low_byte_counter_d = pwdata[7:0]; // R18
    end
  end

  // High-byte counter next value
  always @* begin
    high_byte_counter_d = high_byte_counter_q;
    if (do_restart || do_reset) begin
      high_byte_counter_d = `SDBT_ZERO8; // R23
    end else if (step || do_update) begin
      high_byte_counter_d = (high_byte_counter_q == `SDBT_ZERO8) ? htop_q : high_byte_counter_q - 8'h01; // R22
    end
    if (high_byte_counter_wr) begin
      high_byte_counter_d = pwdata[7:0]; // R21
    end
  end

  // Flags: a hardware set wins over a write-one clear in one cycle
  always @* begin
    flags_d = flags_q;
    if (wr && hit_flags) begin
      flags_d = flags_q & ~(pwdata[7:0] & `SDBT_FLAGS_MASK);
    end
    if (low_underflow) begin
      flags_d[`SDBT_FLAG_LOW_UNDERFLOW] = 1'b1; // R16
    end
    if (high_underflow) begin
      flags_d[`SDBT_FLAG_HIGH_UNDERFLOW] = 1'b1; // R15
    end
    if (ctrl_q[`SDBT_ENABLE_BIT]) begin
      flags_d[`SDBT_FLAG_LCMP0 +: 3] = flags_d[`SDBT_FLAG_LCMP0 +: 3] | low_hit; // R14
    end
  end

  // Counter flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_counter_q <= `SDBT_ZERO8;
      high_byte_counter_q <= `SDBT_ZERO8;
    end else begin
      low_byte_counter_q <= low_byte_counter_d;
      high_byte_counter_q <= high_byte_counter_d;
    end
  end

  // Sticky flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `SDBT_ZERO8;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Waveform pins come straight from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_pin <= 6'h00;
    end else begin
      waveform_pin <= wave_d;
    end
  end

  // Interrupt request: any flag whose enable is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_d & inten_q & `SDBT_FLAGS_MASK); // R11 R12 R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB writes: each register has its own flop group
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SDBT_ZERO8;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= pwdata[7:0] & 8'h0F; // R1 R2
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpen_q <= `SDBT_ZERO8;
    end else if (wr && hit_cmpen) begin
      cmpen_q <= pwdata[7:0] & `SDBT_CH_MASK; // R3
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oval_q <= `SDBT_ZERO8;
    end else if (wr && hit_oval) begin
      oval_q <= pwdata[7:0] & `SDBT_CH_MASK; // R4
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      split_q <= `SDBT_ZERO8;
    end else if (wr && hit_split) begin
      split_q <= pwdata[7:0] & 8'h01; // R5
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmdstat_q <= `SDBT_ZERO8;
    end else if (wr && hit_cmdclr) begin
      cmdstat_q <= cmdstat_q & ~(pwdata[7:0] & `SDBT_CMDSTAT_MASK); // R6
    end else if (wr && hit_cmdset) begin
      cmdstat_q <= cmdstat_q | (pwdata[7:0] & `SDBT_CMDSTAT_MASK); // R7
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten_q <= `SDBT_ZERO8;
    end else if (wr && hit_inten) begin
      inten_q <= pwdata[7:0] & `SDBT_FLAGS_MASK; // R11 R12 R13
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_q <= `SDBT_ZERO8;
    end else if (wr && hit_dbg) begin
      dbg_q <= pwdata[7:0] & 8'h01; // R17
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ltop_q <= `SDBT_TOP_RESET; // R19
    end else if (wr && hit_ltop) begin
      ltop_q <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      htop_q <= `SDBT_TOP_RESET; // R19
    end else if (wr && hit_htop) begin
      htop_q <= pwdata[7:0];
    end
  end

  // Compare values, one flop word per channel and byte
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 6; i = i + 1) begin
        cmp_q[i] <= `SDBT_ZERO8;
      end
    end else if (wr && hit_cmp) begin
      cmp_q[cmp_idx] <= pwdata[7:0]; // R20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB reads, answered in the access cycle
  reg [7:0] rd_d;
  reg err_d;
  always @* begin
    rd_d = `SDBT_ZERO8;
    err_d = 1'b0;
    if (sel_hit(paddr, `SDBT_IDX_CTRL)) begin
      rd_d = ctrl_q;
    end else if (sel_hit(paddr, `SDBT_IDX_CMPEN)) begin
      rd_d = cmpen_q;
    end else if (sel_hit(paddr, `SDBT_IDX_OVAL)) begin
      rd_d = oval_q;
    end else if (sel_hit(paddr, `SDBT_IDX_SPLIT)) begin
      rd_d = split_q;
    end else if (sel_hit(paddr, `SDBT_IDX_CMDCLR) || sel_hit(paddr, `SDBT_IDX_CMDSET)) begin
      rd_d = cmdstat_q; // R8 R10
    end else if (sel_hit(paddr, `SDBT_IDX_INTEN)) begin
      rd_d = inten_q;
    end else if (sel_hit(paddr, `SDBT_IDX_FLAGS)) begin
      rd_d = flags_q;
    end else if (sel_hit(paddr, `SDBT_IDX_DBG)) begin
      rd_d = dbg_q;
    end else if (sel_hit(paddr, `SDBT_IDX_LOW_BYTE_COUNTER)) begin
      rd_d = low_byte_counter_q;
    end else if (sel_hit(paddr, `SDBT_IDX_HIGH_BYTE_COUNTER)) begin
      rd_d = high_byte_counter_q;
    end else if (sel_hit(paddr, `SDBT_IDX_LTOP)) begin
      rd_d = ltop_q;
    end else if (sel_hit(paddr, `SDBT_IDX_HTOP)) begin
      rd_d = htop_q;
    end else if (paddr[31:2] >= {22'h000000, `SDBT_IDX_LCMP0} &&
                 paddr[31:2] <= {22'h000000, `SDBT_IDX_HCMP2}) begin
      rd_d = cmp_q[paddr[4:2]];
    end else begin
      // Unmapped words answer with an error and read as zero
      err_d = 1'b1;
    end
  end

  // Answer in the first access cycle: pready rises registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & err_d;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_d} : 32'h00000000;
    end
  end

endmodule

// [rtl/sdbt_consts.vh]
// Offsets, field positions, reset values and command codes of the split dual-byte timer
`ifndef SDBT_CONSTS_VH
`define SDBT_CONSTS_VH
`define SDBT_IDX_CTRL 8'h00
`define SDBT_IDX_CMPEN 8'h01
`define SDBT_IDX_OVAL 8'h02
`define SDBT_IDX_SPLIT 8'h03
`define SDBT_IDX_CMDCLR 8'h04
`define SDBT_IDX_CMDSET 8'h05
`define SDBT_IDX_INTEN 8'h0A
`define SDBT_IDX_FLAGS 8'h0B
`define SDBT_IDX_DBG 8'h0E
`define SDBT_IDX_LOW_BYTE_COUNTER 8'h20
`define SDBT_IDX_HIGH_BYTE_COUNTER 8'h21
`define SDBT_IDX_LTOP 8'h26
`define SDBT_IDX_HTOP 8'h27
`define SDBT_IDX_LCMP0 8'h28
`define SDBT_IDX_HCMP2 8'h2D
`define SDBT_ENABLE_BIT 0
`define SDBT_DIVSEL_MSB 3
`define SDBT_DIVSEL_LSB 1
`define SDBT_CMD_MSB 3
`define SDBT_CMD_LSB 2
`define SDBT_CMD_UPDATE 2'h1
`define SDBT_CMD_RESTART 2'h2
`define SDBT_CMD_RESET 2'h3
`define SDBT_FLAG_LOW_UNDERFLOW 0
`define SDBT_FLAG_HIGH_UNDERFLOW 1
`define SDBT_FLAG_LCMP0 4
`define SDBT_FLAGS_MASK 8'h73
`define SDBT_CH_MASK 8'h77
`define SDBT_TOP_RESET 8'hFF
`define SDBT_ZERO8 8'h00
`define SDBT_CMDSTAT_MASK 8'hF3
`endif

// [tb/sdbt_timer_checker.sv]
// Port-level assertions for the split dual-byte timer
module sdbt_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire debug_halt,
  input wire [5:0] waveform_pin,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic en_q;
  logic [7:0] ov_q, ie_q;
  wire wr_ok = psel && penable && pready && pwrite;
  wire rd_ok = psel && penable && pready && !pwrite;
  // Shadows of enable, idle level and interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'h0;
      ov_q <= 8'h00;
      ie_q <= 8'h00;
    end else if (wr_ok) begin
      if (paddr[31:2] == 30'h0) en_q <= pwdata[0];
      if (paddr[31:2] == 30'h2) ov_q <= pwdata[7:0];
      if (paddr[31:2] == 30'hA) ie_q <= pwdata[7:0];
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_read_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad error reply");
  upper_zero_a: assert property (rd_ok |-> prdata[31:8] == 24'h0) else $error("upper bits");
  cmd_reads_zero_a: assert property (
    rd_ok && paddr[31:3] == 29'h2 |-> prdata[3:2] == 2'h0) else $error("cmd field read");
  idle_level_a: assert property (
    !en_q && $past(!en_q) && $stable(ov_q) |-> waveform_pin == {ov_q[6:4], ov_q[2:0]})
    else $error("idle level");
  irq_masked_a: assert property (
    ie_q == 8'h00 && $past(ie_q) == 8'h00 |-> !irq) else $error("masked irq");
endmodule
////////////////////////////////////////////////////////////////
bind sdbt_timer sdbt_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .debug_halt(debug_halt),
  .waveform_pin(waveform_pin), .irq(irq));

// [tb/sdbt_timer_tb_top.sv]
// Self-checking bench for the split dual-byte timer
module split_dual_byte_timer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, debug_halt = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, lf = 32'h23AC38AE, rv;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [5:0] waveform_pin;
  logic [32:0] exp_q[$];
  logic [7:0] ri[5] = '{8'h01, 8'h02, 8'h03, 8'h0A, 8'h0E};
  logic [7:0] rm[5] = '{8'h77, 8'h77, 8'h01, 8'h73, 8'h01};
  int dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  int n_mismatch = 0, samples_checked = 0, d;
  always #4 pclk = ~pclk;
  sdbt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_halt(debug_halt), .waveform_pin(waveform_pin), .irq(irq));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'h0};
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 50);
    if (pready !== 1'h1) begin
      n_mismatch++;
      stop_test();
    end
    rv = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'h1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'h0, a, 8'h00);
  endtask
  // Read results are compared against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    #600000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ri[k]) rd(ri[k], 33'h0);
    rd(8'h0B, 33'h0);
    rd(8'h26, 33'hFF);
    rd(8'h27, 33'hFF);
    rd(8'h06, 33'h100000000);
    foreach (ri[k]) begin
      lf = nxt(lf);
      wr(ri[k], lf[7:0]);
      rd(ri[k], {25'h0, lf[7:0] & rm[k]});
      if (k == 1) chk({27'h0, waveform_pin}, {27'h0, lf[6:4], lf[2:0]});
    end
    $display("register test done");
    wr(8'h05, 8'hFF);
    rd(8'h04, 33'hF3);
    wr(8'h04, 8'h30);
    rd(8'h05, 33'hC3);
    wr(8'h04, 8'hC3);
    rd(8'h04, 33'h0);
    $display("status test done");
    wr(8'h03, 8'h01);
    wr(8'h20, 8'h5A);
    repeat (20) @(posedge pclk);
    rd(8'h20, 33'h5A);
    wr(8'h05, 8'h04);
    rd(8'h20, 33'h59);
    wr(8'h05, 8'h08);
    rd(8'h20, 33'h0);
    wr(8'h0E, 8'h00);
    debug_halt <= 1'h1;
    wr(8'h20, 8'h33);
    wr(8'h28, 8'h40);
    wr(8'h2A, 8'h10);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h03);
    wr(8'h05, 8'h0C);
    rd(8'h20, 33'h33);
    chk({27'h0, waveform_pin}, 33'h01);
    wr(8'h0E, 8'h01);
    repeat (10) @(posedge pclk);
    apb(1'h0, 8'h20, 8'h00);
    chk({32'h0, rv[7:0] != 8'h33}, 33'h1);
    debug_halt <= 1'h0;
    wr(8'h00, 8'h00);
    wr(8'h05, 8'h0C);
    rd(8'h20, 33'h0);
    $display("command test done");
    wr(8'h0B, 8'hFF);
    wr(8'h0A, 8'h00);
    wr(8'h00, 8'h01);
    repeat (600) @(posedge pclk);
    wr(8'h00, 8'h00);
    rd(8'h0B, 33'h73);
    wr(8'h0B, 8'h01);
    rd(8'h0B, 33'h72);
    wr(8'h0A, 8'h02);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h1);
    wr(8'h0B, 8'h02);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h0);
    wr(8'h0A, 8'h10);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h1);
    $display("flag test done");
    foreach (dv[k]) begin
      wr(8'h20, 8'h40);
      wr(8'h00, {4'h0, 3'(k), 1'h1});
      repeat (16 * dv[k]) @(posedge pclk);
      wr(8'h00, 8'h00);
      apb(1'h0, 8'h20, 8'h00);
      d = 8'h40 - rv[7:0];
      chk({32'h0, d >= 15 && d <= 20}, 33'h1);
    end
    $display("divider test done");
    stop_test();
  end
endmodule
